// file: design/hitf_defs.svh
/*
 * Constants of the host interval timer and free counter: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 250 MHz core clock and a byte-addressed register bus.
 */
// Function
// - The interval timer runs while its enable bit is one and holds its count while it is zero.
// - A one-to-zero change of the enable bit forces the stored preload to all ones.
// - Software writes a 16-bit preload, and the enabled timer starts from it and counts down.
// - The present timer value reads in a read-only field that resets to all ones.
// - The timer can raise a host interrupt at the period that the preload sets.
// - The free counter starts at zero after reset and adds one every 25 MHz cycle.
// - The free counter is 32 bits wide and wraps from its maximum to zero without stopping.
// - After reset the free counter reads zero within 160 ns.
`ifndef HITF_DEFS_SVH
`define HITF_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define HITF_ADDR_W      8
`define HITF_OFS_CFG     8'h8C
`define HITF_OFS_CNT     8'h90
`define HITF_OFS_FREE    8'h9C
`define HITF_OFS_STAT    8'hA0

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define HITF_EN_BIT      29
`define HITF_LOAD_RST    16'hFFFF
`define HITF_CNT_RST     16'hFFFF
`define HITF_FREE_RST    32'h0000_0000
`define HITF_ZERO16      16'h0000
`define HITF_ZERO32      32'h0000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define HITF_CLK_HZ      250000000
`define HITF_CLK_NS      4
`define HITF_FREE_HZ     25000000
`define HITF_PRE_DIV     (`HITF_CLK_HZ / `HITF_FREE_HZ)
`define HITF_CLR_NS      160
`define HITF_CLR_CYC     (`HITF_CLR_NS / `HITF_CLK_NS)

`endif

// file: design/hitf_pkg.sv
/*
 * Types shared by the timer block.
 * Assumes hitf_defs.svh holds the numbers.
 */
package hitf_pkg;

    // Register bus answer state
    typedef enum logic {
        HITF_BUS_IDLE,
        HITF_BUS_ACK
    } hitf_bus_type;

endpackage : hitf_pkg

// file: design/hitf_tick_if.sv
/*
 * Carrier between the free counter and the register block.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps
interface hitf_tick_if;
    logic        tick;   // One-cycle 25 MHz tick
    logic [31:0] count;  // Free counter value

    modport prov (output tick, output count);
    modport user (input tick, input count);
endinterface : hitf_tick_if

// file: design/hitf_free_counter.sv
/*
 * Free-running 32-bit counter advanced at 25 MHz, with the tick that drives it.
 * Assumes a 250 MHz clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "hitf_defs.svh"
module hitf_free_counter (
    input  wire logic   clock,
    input  wire logic   rst,
    hitf_tick_if.prov   tk
);
    import hitf_pkg::*;

    localparam int          CLR_MAX = `HITF_CLR_CYC;
    localparam logic [3:0]  PRE_MAX = 4'(`HITF_PRE_DIV - 1);

    logic [3:0]  pre_q,  pre_d;
    logic [31:0] cnt_q,  cnt_d;
    logic        tick_q, tick_d;

    // ****************************************************************
    // Prescaler and counter
    // ****************************************************************
    // Next values
    always_comb begin
        tick_d = (pre_q == PRE_MAX);
        pre_d  = tick_d ? 4'h0 : 4'(pre_q + 4'h1);
        cnt_d  = tick_q ? 32'(cnt_q + 32'h1) : cnt_q;  // Wraps on overflow
    end

    // Registers, cleared by reset at once
    always_ff @(posedge clock) begin
        if (rst) begin
            pre_q  <= 4'h0;
            tick_q <= 1'b0;
            cnt_q  <= `HITF_FREE_RST;
        end else begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
            cnt_q  <= cnt_d;
        end
    end

    assign tk.tick  = tick_q;
    assign tk.count = cnt_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Cycles since the last tick, for the spacing check; all ones until the first tick
    localparam logic [3:0]  GAP_NONE = 4'hF;

    logic [3:0]  gap_q,  gap_d;

    // Next gap count, held at its marker before the first tick
    always_comb begin
        gap_d = gap_q;
        if (tick_q) begin
            gap_d = 4'h0;
        end else if (gap_q != GAP_NONE) begin
            gap_d = 4'(gap_q + 4'h1);
        end
    end

    // Gap register
    always_ff @(posedge clock) begin
        if (rst) begin
            gap_q <= GAP_NONE;
        end else begin
            gap_q <= gap_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_free_clear_time: assert property ($fell(rst) |-> ##[0:CLR_MAX] (cnt_q == 32'h0))
        else $error("free counter not cleared after reset");
    a_free_tick_step: assert property (tick_q |=> cnt_q == 32'($past(cnt_q) + 32'h1))
        else $error("free counter missed a tick");
    a_free_hold_between: assert property (!tick_q |=> $stable(cnt_q))
        else $error("free counter moved without a tick");
    a_free_tick_rate: assert property ((gap_q != GAP_NONE) |->
                                       (tick_q ? gap_q == PRE_MAX : gap_q < PRE_MAX))
        else $error("tick spacing is not ten cycles");
    a_free_wrap_zero: assert property ((tick_q && cnt_q == 32'hFFFF_FFFF) |=> cnt_q == 32'h0)
        else $error("free counter did not wrap");
endmodule : hitf_free_counter

// file: design/hitf_timer.sv
/*
 * Host interval timer and free counter with an Avalon-MM slave.
 * Assumes an Avalon master that holds each request until waitrequest is low.
 */
`timescale 1ns/100ps
`include "hitf_defs.svh"
module hitf_timer (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic [`HITF_ADDR_W-1:0]  avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    output logic                          timer_irq
);
    import hitf_pkg::*;

    // Address decode used by reads and writes
    function automatic logic hit(input logic [`HITF_ADDR_W-1:0] a,
                                 input logic [`HITF_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    hitf_tick_if tk ();

    hitf_free_counter u_free (
        .clock (clock),
        .rst   (rst),
        .tk    (tk)
    );

    hitf_bus_type  bus_q,  bus_d;
    logic [31:0]   rdata_q, rdata_d;
    logic          en_q,   en_d;
    logic [15:0]   load_q, load_d;
    logic [15:0]   cnt_q,  cnt_d;
    logic          flag_q, flag_d;
    logic          req, wr_go, expire;

    // ****************************************************************
    // Bus slave: one wait cycle, then answer
    // ****************************************************************
    // Request decode and read mux
    always_comb begin
        req     = avs_read | avs_write;
        bus_d   = HITF_BUS_IDLE;
        rdata_d = rdata_q;
        unique case (bus_q)
            HITF_BUS_IDLE: begin
                if (req) begin
                    bus_d   = HITF_BUS_ACK;
                    rdata_d = `HITF_ZERO32;  // Unmapped reads give zero
                    if (hit(avs_address, `HITF_OFS_CFG)) begin
                        rdata_d[`HITF_EN_BIT] = en_q;
                        rdata_d[15:0]         = load_q;
                    end
                    if (hit(avs_address, `HITF_OFS_CNT)) begin
                        rdata_d[15:0] = cnt_q;
                    end
                    if (hit(avs_address, `HITF_OFS_FREE)) begin
                        rdata_d = tk.count;
                    end
                    if (hit(avs_address, `HITF_OFS_STAT)) begin
                        rdata_d[0] = flag_q;
                    end
                end
            end
            HITF_BUS_ACK: bus_d = HITF_BUS_IDLE;
        endcase
    end

    // Bus registers
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_q   <= HITF_BUS_IDLE;
            rdata_q <= `HITF_ZERO32;
        end else begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = req & (bus_q == HITF_BUS_IDLE);
    assign avs_readdata    = rdata_q;
    assign wr_go           = avs_write & (bus_q == HITF_BUS_ACK);

    // ****************************************************************
    // Interval timer
    // ****************************************************************
    // Control, preload, count and status flag
    always_comb begin
        en_d   = en_q;
        load_d = load_q;
        flag_d = flag_q;
        if (wr_go && hit(avs_address, `HITF_OFS_CFG)) begin
            for (int b = 0; b < 2; b++) begin
                if (avs_byteenable[b]) begin
                    load_d[b*8 +: 8] = avs_writedata[b*8 +: 8];
                end
            end
            if (avs_byteenable[`HITF_EN_BIT/8]) begin
                en_d = avs_writedata[`HITF_EN_BIT];
            end
        end
        if (en_q && !en_d) begin
            load_d = `HITF_LOAD_RST;
        end
        expire = en_q && tk.tick && (cnt_q == `HITF_ZERO16);
        if (wr_go && hit(avs_address, `HITF_OFS_STAT) &&
            avs_byteenable[0] && avs_writedata[0]) begin
            flag_d = 1'b0;                                             // Write one clears
        end
        if (expire) begin
            flag_d = 1'b1;                                             // Set wins
        end
        cnt_d = cnt_q;
        if (!en_q && en_d) begin
            cnt_d = load_d;                                            // Start at preload
        end else if (en_q && tk.tick) begin
            cnt_d = expire ? load_q : 16'(cnt_q - 16'h1);
        end
    end

    // Timer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            en_q   <= 1'b0;
            load_q <= `HITF_LOAD_RST;
            cnt_q  <= `HITF_CNT_RST;
            flag_q <= 1'b0;
        end else begin
            en_q   <= en_d;
            load_q <= load_d;
            cnt_q  <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign timer_irq = flag_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_timer_halt_hold: assert property ((!en_q && $stable(en_q)) |=> $stable(cnt_q) || en_q)
        else $error("timer moved while halted");
    a_timer_runs_down: assert property ((en_q && tk.tick && cnt_q != 16'h0 && $past(en_q))
                                        |=> cnt_q == 16'($past(cnt_q) - 16'h1))
        else $error("timer did not decrement");
    a_disable_preset_load: assert property ($fell(en_q) |-> load_q == 16'hFFFF)
        else $error("preload not forced on disable");
    a_enable_starts_load: assert property ($rose(en_q) |-> cnt_q == load_q)
        else $error("timer did not start at preload");
    a_expire_reload_flag: assert property (expire |=> cnt_q == $past(load_q) && flag_q)
        else $error("expiry did not reload and flag");
    a_irq_follows_flag: assert property (expire |=> timer_irq)
        else $error("interrupt not raised on expiry");
    a_bus_one_wait: assert property ((req && bus_q == HITF_BUS_IDLE) |=> !avs_waitrequest)
        else $error("bus answer not after one wait");
    a_cnt_reads_zero_top: assert property ((bus_q == HITF_BUS_ACK && $past(hit(avs_address,
                                           `HITF_OFS_CNT))) |-> rdata_q[31:16] == 16'h0)
        else $error("reserved count bits not zero");
    a_flag_sticky: assert property ((flag_q && !wr_go) |=> flag_q)
        else $error("status flag dropped by itself");

    c_timer_expiry: cover property (expire);
    c_timer_disable: cover property ($fell(en_q));
    c_flag_cleared: cover property ($fell(flag_q));
endmodule : hitf_timer

// file: verification/testbench.sv
/*
 * Self-checking bench of the host interval timer and free counter.
 * Assumes the design files compile first and that hitf_defs.svh is on the include path.
 */
`timescale 1ns/100ps
`include "hitf_defs.svh"
module testbench;
    import hitf_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clock;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        timer_irq;
    logic [31:0] rd;
    logic [31:0] rd2;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t1;
    int          t2;

    hitf_timer u_hitf_timer (
        .clock          (clock),
        .rst            (rst),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .timer_irq      (timer_irq)
    );

    // Clock and cycle count
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Verdict and end of run
    task final_report;
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // A bound ran out
    task give_up;
        n_fail++;
        final_report();
    endtask : give_up

    // Compare seen against expected
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Bus cycle held until waitrequest is sampled low, then released
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             input logic [3:0] be, output logic [31:0] d);
        int i;
        i = 0;
        avs_address    <= a;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do begin
            @(posedge clock);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (i >= 50) give_up();
        d = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus

    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, 4'h0, d);
    endtask : bus_rd

    task bus_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] dummy;
        bus(1'b1, a, wd, be, dummy);
    endtask : bus_wr

    // Hold reset eight cycles, leave two quiet cycles after release
    task do_reset;
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : do_reset

    // Values right after reset, free counter read first
    task reset_values;
        bus_rd(`HITF_OFS_FREE, rd);
        chk("free", rd, 32'h0000_0000);
        bus_rd(`HITF_OFS_CFG, rd);
        chk("cfg", rd, 32'h0000_FFFF);
        bus_rd(`HITF_OFS_CNT, rd);
        chk("count", rd, 32'h0000_FFFF);
        chk("irq", {31'h0, timer_irq}, 32'h0);
    endtask : reset_values

    // Wait for the timer flag, note the cycle
    task wait_irq(output int t);
        int i;
        i = 0;
        while (timer_irq !== 1'b1 && i < 2000) begin
            @(posedge clock);
            i++;
        end
        if (i >= 2000) give_up();
        t = cyc;
    endtask : wait_irq

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        rst            <= 1'b1;
        avs_address    <= 8'h00;
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        avs_writedata  <= 32'h0;
        avs_byteenable <= 4'h0;
        do_reset();
        reset_values();
        // Read-only places ignore writes, unmapped places read zero
        bus_wr(`HITF_OFS_CNT, 32'h0000_1234, 4'hF);
        bus_rd(`HITF_OFS_CNT, rd);
        chk("count_ro", rd, 32'h0000_FFFF);
        bus_wr(`HITF_OFS_FREE, 32'hFFFF_FFFF, 4'hF);
        bus_rd(`HITF_OFS_FREE, rd);
        chk("free_ro", {16'h0, rd[31:16]}, 32'h0);
        bus_rd(8'h40, rd);
        chk("unmapped", rd, 32'h0);
        // Free counter pace over 100 clocks
        bus_rd(`HITF_OFS_FREE, rd);
        repeat (97) @(posedge clock);
        bus_rd(`HITF_OFS_FREE, rd2);
        chk("free_step", rd2 - rd, 32'(100 / `HITF_PRE_DIV));
        // Preload bytes alone leave the timer off
        bus_wr(`HITF_OFS_CFG, 32'h2000_0007, 4'h3);
        bus_rd(`HITF_OFS_CFG, rd);
        chk("cfg_low", rd, 32'h0000_0007);
        // Enable with preload 5, reserved bits written as ones
        bus_wr(`HITF_OFS_CFG, 32'hFFFF_0005, 4'hF);
        bus_rd(`HITF_OFS_CFG, rd);
        chk("cfg_on", rd, 32'h2000_0005);
        bus_rd(`HITF_OFS_CNT, rd);
        chk("count_start", {31'h0, rd <= 32'd5}, 32'h1);
        // Expiry, clear, and the period between two expiries
        wait_irq(t1);
        bus_wr(`HITF_OFS_STAT, 32'h1, 4'hF);
        bus_rd(`HITF_OFS_STAT, rd);
        chk("stat_clr", rd, 32'h0);
        wait_irq(t2);
        chk("period", 32'(t2 - t1), 32'(6 * `HITF_PRE_DIV));
        // Disable with fresh preload bytes: preload forced, count held
        bus_wr(`HITF_OFS_CFG, 32'h0000_1234, 4'hF);
        bus_rd(`HITF_OFS_CFG, rd);
        chk("cfg_off", rd, 32'h0000_FFFF);
        bus_rd(`HITF_OFS_CNT, rd);
        repeat (50) @(posedge clock);
        bus_rd(`HITF_OFS_CNT, rd2);
        chk("count_hold", rd2, rd);
        // Reset in mid-run
        bus_wr(`HITF_OFS_CFG, 32'h2000_0003, 4'hF);
        repeat (20) @(posedge clock);
        do_reset();
        reset_values();
        final_report();
    end

endmodule : testbench
